// ===== src/gdsl_status.sv
`include "gdsl_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Contract
// RULE1: Temperature output is a 9 kHz PWM, duty refreshed once per period.
// RULE2: High pulse never narrower than 30 ns, the width seen at 20 C and below.
// RULE3: Duty spans about 3% to 80% over 25 C to 150 C.
// RULE4: Reader converts duty to temperature as 162.3 times duty plus 20.1.
// RULE5: Above 150 C duty keeps rising linearly until the fault trips.
// RULE6: During overtemperature the output stays high; modulation resumes after hysteresis.
// RULE7: A falling command edge moves the diode controller to state 1, switch off.
// RULE8: State 1 holds off for a fixed blanking time, then always goes to state 2.
// RULE9: State 2 keeps switch off; negative drain voltage moves to state 3.
// RULE10: Entering overtemperature shutdown starts the diode controller in state 2; the code enters state 1 if the command falls in the same cycle.
// RULE11: State 3 turns switch on; forward current returns to state 2.
// RULE12: With an idle command the controller only alternates states 2 and 3.
// RULE13: Controller toggles an overheated switch first before driving the opposite one.
// RULE14: On each command rise, check whether drain voltage had gone below zero; the code ignores rises while a flag delay or pulse is running.
// RULE15: Confirmed soft turn-on gives one fixed-width flag pulse after a fixed delay.
// RULE16: Reverse conduction shorter than the qualifying time gives no flag pulse.
// RULE17: Hard or partial hard switching keeps the flag low for that cycle.
// RULE18: Past the overtemperature trip, the diode controller gates the switch, not the command.
// RULE19: Leaving driver overtemperature while still hot resumes diode-controller operation.
// RULE20: Blanking, flag delay, flag width and qualify time are parameterised cycle counts.
module gdsl_status
    import gdsl_pkg::*;
#(
    parameter int unsigned PWM_PERIOD_CYC = `GDSL_PWM_PERIOD_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       sw_cmd_i,
    input  wire logic [7:0] temp_c_i,
    input  wire logic       gan_ot_i,
    input  wire logic       drv_ot_i,
    input  wire logic       vds_neg_i,
    input  wire logic       fwd_cur_i,
    output logic            temp_pwm_o,
    output logic            gate_on_o,
    output logic            thermal_shutdown_o,
    output logic            thermal_ideal_diode_mode_o,
    output logic            soft_switch_flag_out_o
);

    localparam int unsigned FRAC_K   = (PWM_PERIOD_CYC << `GDSL_FRAC_BITS) / `GDSL_TJ_SLOPE_X10;
    localparam logic [31:0] PERIOD_L = 32'(PWM_PERIOD_CYC);
    localparam logic [31:0] MIN_HI   = 32'(`GDSL_PWM_MIN_CYC);
    localparam gdsl_cnt_t   QUAL_CYC = gdsl_cnt_t'(`GDSL_QUAL_CYC);
    localparam int          BLANK_WAIT = `GDSL_BLANK_CYC + 1;
    localparam int          FLAG_AT    = `GDSL_FLAG_DLY_CYC + 1;

    ////////////////////////////////////////////////////////////////////////////
    // Command edges and overtemperature state.

    logic cmd_r;
    logic cmd_nxt;
    logic ts_r;
    logic ts_nxt;
    logic cmd_fall;
    logic cmd_rise;
    logic hot;
    logic idm_ok;

    assign cmd_fall = cmd_r && !sw_cmd_i;
    assign cmd_rise = !cmd_r && sw_cmd_i;
    assign hot      = gan_ot_i || drv_ot_i;
    assign idm_ok   = gan_ot_i && !drv_ot_i;

    always_comb begin
        cmd_nxt = sw_cmd_i;
        ts_nxt  = hot;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_r <= 1'b0;
            ts_r  <= 1'b0;
        end else begin
            cmd_r <= cmd_nxt;
            ts_r  <= ts_nxt;
        end
    end

    assign thermal_shutdown_o = ts_r;

    ////////////////////////////////////////////////////////////////////////////
    // Temperature PWM.

    logic [31:0] pcnt_r;
    logic [31:0] pcnt_nxt;
    logic [31:0] hi_r;
    logic [31:0] hi_nxt;
    logic        pwm_r;
    logic        pwm_nxt;
    logic        wrap;
    logic [31:0] tenths;
    logic [31:0] above;
    logic [31:0] target;

    assign wrap = (pcnt_r == PERIOD_L - 32'h0000_0001);

    always_comb begin
        tenths = 32'(temp_c_i) * 32'h0000_000a;
        above  = 32'h0000_0000;
        if (tenths > 32'(`GDSL_TJ_OFFS_X10)) begin
            above = tenths - 32'(`GDSL_TJ_OFFS_X10);
        end
        target = (above * 32'(FRAC_K)) >> `GDSL_FRAC_BITS; // RULE3 RULE5
        if (target < MIN_HI) begin
            target = MIN_HI; // RULE2
        end
        if (target > PERIOD_L) begin
            target = PERIOD_L;
        end
        pcnt_nxt = wrap ? 32'h0000_0000 : pcnt_r + 32'h0000_0001;
        hi_nxt   = wrap ? target : hi_r; // RULE1
        pwm_nxt  = hot || (pcnt_nxt < hi_r); // RULE6
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            // Starting on the last count makes the first period after reset a full one.
            pcnt_r <= PERIOD_L - 32'h0000_0001;
            hi_r   <= MIN_HI;
            pwm_r  <= 1'b0;
        end else begin
            pcnt_r <= pcnt_nxt;
            hi_r   <= hi_nxt;
            pwm_r  <= pwm_nxt;
        end
    end

    assign temp_pwm_o = pwm_r;

    ////////////////////////////////////////////////////////////////////////////
    // Thermal ideal-diode controller and switch gating.

    gdsl_idm_t idm_r;
    gdsl_idm_t idm_nxt;
    logic      gate_r;
    logic      gate_nxt;

    gdsl_tmr_if blank_if ();

    gdsl_timer #(
        .CYCLES (gdsl_cnt_t'(`GDSL_BLANK_CYC)) // RULE20
    ) u_blank (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tmr   (blank_if.tmr)
    );

    assign blank_if.start = idm_ok && cmd_fall; // RULE7

    always_comb begin
        idm_nxt = idm_r;
        if (!idm_ok) begin
            idm_nxt = IDM_OFF;
        end else if (cmd_fall) begin
            idm_nxt = IDM_BLANK; // RULE7
        end else begin
            case (idm_r)
                IDM_OFF: begin
                    idm_nxt = IDM_WATCH; // RULE10 RULE19
                end
                IDM_BLANK: begin
                    if (blank_if.done) begin
                        idm_nxt = IDM_WATCH; // RULE8
                    end
                end
                IDM_WATCH: begin
                    if (vds_neg_i) begin
                        idm_nxt = IDM_ON; // RULE9 RULE12
                    end
                end
                IDM_ON: begin
                    if (fwd_cur_i) begin
                        idm_nxt = IDM_WATCH; // RULE11 RULE12
                    end
                end
                default: begin
                    idm_nxt = IDM_OFF;
                end
            endcase
        end
        if (idm_nxt == IDM_OFF) begin
            gate_nxt = sw_cmd_i && !hot;
        end else begin
            gate_nxt = (idm_nxt == IDM_ON); // RULE18
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            idm_r  <= IDM_OFF;
            gate_r <= 1'b0;
        end else begin
            idm_r  <= idm_nxt;
            gate_r <= gate_nxt;
        end
    end

    assign gate_on_o                  = gate_r;
    assign thermal_ideal_diode_mode_o = (idm_r != IDM_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Soft-switch detection and flag pulse.

    gdsl_cnt_t qual_r;
    gdsl_cnt_t qual_nxt;
    logic      qualified;
    logic      flag_start;

    gdsl_tmr_if dly_if ();
    gdsl_tmr_if wid_if ();

    gdsl_timer #(
        .CYCLES (gdsl_cnt_t'(`GDSL_FLAG_DLY_CYC))
    ) u_dly (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tmr   (dly_if.tmr)
    );

    gdsl_timer #(
        .CYCLES (gdsl_cnt_t'(`GDSL_FLAG_WID_CYC))
    ) u_wid (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tmr   (wid_if.tmr)
    );

    // Reverse conduction must last the whole qualifying time without a break.
    always_comb begin
        qual_nxt = 16'h0000;
        if (vds_neg_i) begin
            qual_nxt = (qual_r == QUAL_CYC) ? qual_r : qual_r + 16'h0001; // RULE16
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            qual_r <= 16'h0000;
        end else begin
            qual_r <= qual_nxt;
        end
    end

    assign qualified    = (qual_r == QUAL_CYC);
    assign flag_start   = cmd_rise && qualified && !dly_if.busy && !wid_if.busy; // RULE14 RULE17
    assign dly_if.start = flag_start;
    assign wid_if.start = dly_if.done; // RULE15

    assign soft_switch_flag_out_o = wid_if.busy;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i);
    endclocking

    default disable iff (rst_i);

    a_pwm_fault_high: assert property (hot |=> temp_pwm_o) // RULE6
        else $error("temperature output low during overtemperature");

    a_pwm_min_width: assert property ($rose(temp_pwm_o) |-> temp_pwm_o[*3]) // RULE2
        else $error("temperature high pulse narrower than minimum");

    a_pwm_duty_hold: assert property (!wrap |=> $stable(hi_r)) // RULE1
        else $error("duty changed inside a period");

    a_fall_to_blank: assert property (idm_ok && cmd_fall |=> idm_r == IDM_BLANK && !gate_on_o) // RULE7
        else $error("command fall did not enter blanking with switch off");

    a_blank_exits: assert property ($rose(idm_r == IDM_BLANK) |->
                                    ##[1:BLANK_WAIT] idm_r != IDM_BLANK) // RULE8
        else $error("blanking state overstayed");

    a_entry_watch: assert property (idm_r == IDM_OFF && idm_ok && !cmd_fall |=> idm_r == IDM_WATCH) // RULE10
        else $error("shutdown entry did not start in watch state");

    a_watch_to_on: assert property (idm_r == IDM_WATCH && vds_neg_i && idm_ok && !cmd_fall
                                    |=> idm_r == IDM_ON ##0 gate_on_o) // RULE9
        else $error("negative drain voltage did not turn switch on");

    a_on_to_watch: assert property (idm_r == IDM_ON && fwd_cur_i && idm_ok && !cmd_fall
                                    |=> idm_r == IDM_WATCH ##0 !gate_on_o) // RULE11
        else $error("forward current did not turn switch off");

    a_idm_gates: assert property (thermal_ideal_diode_mode_o |-> gate_on_o == (idm_r == IDM_ON)) // RULE18
        else $error("switch not gated by diode controller");

    a_flag_timing: assert property (flag_start |-> !soft_switch_flag_out_o
                                    ##[FLAG_AT:FLAG_AT] soft_switch_flag_out_o) // RULE15
        else $error("flag pulse not at fixed delay");

    a_flag_hard: assert property (cmd_rise && !qualified && !dly_if.busy |=> !dly_if.busy) // RULE17
        else $error("flag started without qualified reverse conduction");

    c_flag_pulse: cover property (flag_start ##1 dly_if.busy [*2]);
    c_idm_on: cover property (idm_r == IDM_WATCH ##1 idm_r == IDM_ON);
    c_blank_done: cover property (idm_r == IDM_BLANK ##1 idm_r == IDM_WATCH);
    c_fault_pwm: cover property (hot ##1 temp_pwm_o ##1 !hot);

endmodule

// ===== src/gdsl_defs.svh
`ifndef GDSL_DEFS_SVH
`define GDSL_DEFS_SVH

// Clock.
`define GDSL_CLK_HZ         100000000
`define GDSL_CLK_NS         10

// Temperature output modulation.
`define GDSL_PWM_HZ         9000
`define GDSL_PWM_PERIOD_CYC (`GDSL_CLK_HZ / `GDSL_PWM_HZ)
`define GDSL_PWM_MIN_NS     30
`define GDSL_PWM_MIN_CYC    ((`GDSL_PWM_MIN_NS + `GDSL_CLK_NS - 1) / `GDSL_CLK_NS)
`define GDSL_TJ_SLOPE_X10   1623
`define GDSL_TJ_OFFS_X10    201
`define GDSL_FRAC_BITS      16

// Protection and detection timing.
`define GDSL_BLANK_NS       200
`define GDSL_BLANK_CYC      ((`GDSL_BLANK_NS + `GDSL_CLK_NS - 1) / `GDSL_CLK_NS)
`define GDSL_FLAG_DLY_NS    100
`define GDSL_FLAG_DLY_CYC   ((`GDSL_FLAG_DLY_NS + `GDSL_CLK_NS - 1) / `GDSL_CLK_NS)
`define GDSL_FLAG_WID_NS    500
`define GDSL_FLAG_WID_CYC   ((`GDSL_FLAG_WID_NS + `GDSL_CLK_NS - 1) / `GDSL_CLK_NS)
`define GDSL_QUAL_NS        50
`define GDSL_QUAL_CYC       ((`GDSL_QUAL_NS + `GDSL_CLK_NS - 1) / `GDSL_CLK_NS)

`endif

// ===== src/gdsl_pkg.sv
package gdsl_pkg;

    typedef logic [15:0] gdsl_cnt_t;

    typedef enum logic [1:0] {
        IDM_OFF,
        IDM_BLANK,
        IDM_WATCH,
        IDM_ON
    } gdsl_idm_t;

endpackage

// ===== src/gdsl_tmr_if.sv
interface gdsl_tmr_if;
    logic start;
    logic busy;
    logic done;

    modport ctl (output start, input busy, input done);
    modport tmr (input start, output busy, output done);
endinterface

// ===== src/gdsl_timer.sv
`include "gdsl_defs.svh"

// One-shot down counter: start loads CYCLES, busy while counting, done in the last cycle.
module gdsl_timer
    import gdsl_pkg::*;
#(
    parameter gdsl_cnt_t CYCLES = 16'h0001
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    gdsl_tmr_if.tmr   tmr
);

    gdsl_cnt_t cnt_r;
    gdsl_cnt_t cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (tmr.start) begin
            cnt_nxt = CYCLES;
        end else if (cnt_r != 16'h0000) begin
            cnt_nxt = cnt_r - 16'h0001;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign tmr.busy = (cnt_r != 16'h0000);
    assign tmr.done = (cnt_r == 16'h0001) && !tmr.start;

endmodule

// ===== src/gdsl_status_unused_guard.sv
`include "gdsl_defs.svh"

// ===== verification/gdsl_ctrl_model.sv
module gdsl_ctrl_model (
    input  wire logic clk_i,
    output logic      sw_cmd_o,
    output logic      vds_neg_o,
    output logic      fwd_cur_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sw_cmd_o  = 1'b0;
        vds_neg_o = 1'b0;
        fwd_cur_o = 1'b0;
    end

    // Drives one cycle of command and drain levels just after a clock edge.
    task automatic drive(input logic s, input logic v, input logic f);
        @(posedge clk_i);
        sw_cmd_o  <= s;
        vds_neg_o <= v;
        fwd_cur_o <= f;
    endtask

    // Reverse conduction for rc cycles, then turn-on; t_on is when the rise was launched.
    task automatic soft_cycle(input int rc, output longint t_on);
        repeat (2) drive(1'b0, 1'b0, 1'b0);
        repeat (rc) drive(1'b0, 1'b1, 1'b0);
        drive(1'b1, rc > 0, 1'b0);
        t_on = $time;
        repeat (4) drive(1'b1, 1'b0, 1'b0);
        drive(1'b0, 1'b0, 1'b0);
    endtask
endmodule

// ===== verification/gan_driver_status_logic_test.sv
`include "gdsl_defs.svh"

module gan_driver_status_logic_test;
    import gdsl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int P     = 200;
    localparam int K     = (P << 16) / 1623;
    localparam int LIMIT = 8000;
    // The rise is sampled one edge after launch and the flag is seen one edge after it sets.
    localparam int FLAG_T = (`GDSL_FLAG_DLY_CYC + 2) * `GDSL_CLK_NS;

    logic       clk, rst, sw, vneg, fwd, gan_ot, drv_ot;
    logic       pwm, gate, tsd, idm, flag;
    logic [7:0] temp;
    int         err_count, checks_done, cyc, hi_len, fl_len;
    longint     t_on;
    int         pwm_q[$];
    longint     flag_q[$];
    int         rcs[4] = '{8, 2, 0, 8};

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    gdsl_status #(.PWM_PERIOD_CYC(P)) gdsl_status_i (
        .clk_i(clk), .rst_i(rst), .sw_cmd_i(sw), .temp_c_i(temp),
        .gan_ot_i(gan_ot), .drv_ot_i(drv_ot), .vds_neg_i(vneg), .fwd_cur_i(fwd),
        .temp_pwm_o(pwm), .gate_on_o(gate), .thermal_shutdown_o(tsd),
        .thermal_ideal_diode_mode_o(idm), .soft_switch_flag_out_o(flag)
    );

    gdsl_ctrl_model gdsl_ctrl_model_i (.clk_i(clk), .sw_cmd_o(sw), .vds_neg_o(vneg), .fwd_cur_o(fwd));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Holds a temperature for two periods, then notes the expected high count.
    task automatic pwm_case(input logic [7:0] t);
        int tv;
        int e;
        tv = int'(t);
        @(posedge clk);
        temp <= t;
        repeat (2 * P + 5) @(posedge clk);
        e = (10 * tv < 201) ? 3 : ((10 * tv - 201) * K) >>> 16;
        pwm_q.push_back(e < 3 ? 3 : e);
        repeat (P + 5) @(posedge clk);
    endtask

    // Watches the outputs and compares each flag pulse, and each temperature pulse while a note waits, with the oldest note.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (pwm === 1'b1) begin
            hi_len <= hi_len + 1;
        end else begin
            if (hi_len > 0 && pwm_q.size() > 0) chk(hi_len, pwm_q.pop_front());
            hi_len <= 0;
        end
        if (flag === 1'b1) begin
            if (fl_len == 0 && flag_q.size() == 0) chk(1, 0);
            else if (fl_len == 0) chk(32'($time), 32'(flag_q.pop_front()));
            fl_len <= fl_len + 1;
        end else begin
            if (fl_len > 0) chk(fl_len, `GDSL_FLAG_WID_CYC);
            fl_len <= 0;
        end
        if (cyc == LIMIT) begin
            err_count++;
            print_verdict();
        end
    end

    initial begin
        rst    = 1'b1;
        temp   = 8'h00;
        gan_ot = 1'b0;
        drv_ot = 1'b0;
        void'($urandom(37));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        pwm_case(8'h00);
        pwm_case(8'h96);
        repeat (3) pwm_case(8'($urandom_range(150)));
        chk(pwm_q.size(), 0);
        $display("test pwm done");
        foreach (rcs[i]) begin
            gdsl_ctrl_model_i.soft_cycle(rcs[i], t_on);
            if (rcs[i] >= 8) flag_q.push_back(t_on + FLAG_T);
            repeat (70) @(posedge clk);
        end
        gdsl_ctrl_model_i.soft_cycle(8, t_on);
        flag_q.push_back(t_on + FLAG_T);
        gdsl_ctrl_model_i.soft_cycle(8, t_on);
        repeat (80) @(posedge clk);
        chk(flag_q.size(), 0);
        $display("test flag done");
        gdsl_ctrl_model_i.drive(1'b1, 1'b0, 1'b0);
        step(2);
        chk(gate, 1'b1);
        gdsl_ctrl_model_i.drive(1'b0, 1'b0, 1'b0);
        // The command falls before the fault, so that entry lands in watch and not in blanking.
        @(posedge clk);
        gan_ot <= 1'b1;
        step(2);
        chk({idm, gate}, 2'b10);
        gdsl_ctrl_model_i.drive(1'b0, 1'b1, 1'b0);
        step(2);
        chk(gate, 1'b1);
        gdsl_ctrl_model_i.drive(1'b0, 1'b0, 1'b1);
        step(2);
        chk(gate, 1'b0);
        gdsl_ctrl_model_i.drive(1'b0, 1'b1, 1'b0);
        step(2);
        chk(gate, 1'b1);
        gdsl_ctrl_model_i.drive(1'b1, 1'b0, 1'b1);
        step(2);
        chk(gate, 1'b0);
        // The hot switch is toggled first so that it passes through blanking.
        gdsl_ctrl_model_i.drive(1'b0, 1'b1, 1'b0);
        step(19);
        chk(gate, 1'b0);
        step(6);
        chk(gate, 1'b1);
        @(posedge clk);
        drv_ot <= 1'b1;
        step(2);
        chk({idm, gate, tsd}, 3'b001);
        repeat (P) begin
            step(1);
            chk(pwm, 1'b1);
        end
        @(posedge clk);
        drv_ot <= 1'b0;
        step(2);
        chk(idm, 1'b1);
        @(posedge clk);
        gan_ot <= 1'b0;
        step(2);
        chk({idm, tsd}, 2'b00);
        pwm_case(8'h40);
        chk(pwm_q.size(), 0);
        $display("test diode done");
        print_verdict();
    end
endmodule
